/* File: rtl/pwt_top.sv */
`include "pwt_defs.svh"
`default_nettype none
// Function
// - Slow oscillator trim loads from flash after reset
// - Oscillator trim is signed field bits 7..2
// - Top bit lengthens, lower bits shorten, descending
// - Sixteen-bit rate in two bytes sets period
// - Rate writes ignored while feature enabled
// - Slow clock period is 4*(rate+1) ticks
// - Bus clock period is 2*(rate+1) cycles
// - Slow clock first timeout late 1-2 ticks
// - Test register written only in special mode
// - Temperature trim loads from flash after reset
// - Offset enable bit gates the offset trim
// - Offset trim bits are binary weighted
// - Feature enable starts timer, clear stops it
// - Timeout sets flag, write one clears it
// - Interrupt when flag and irq enable set
// - Clock select locked while or when enabling
module pwt_top
   import pwt_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire pwt_apb_req_t apb_req_i,
   output pwt_apb_rsp_t apb_rsp_o,
   input wire logic slow_osc_tick_i,
   input wire logic special_mode_i,
   input wire logic [7:0] flash_osc_trim_i,
   input wire logic [7:0] flash_temp_trim_i,
   output logic signed [5:0] slow_osc_trim_o,
   output logic temp_offset_en_o,
   output logic [3:0] temp_offset_o,
   output logic [7:0] factory_test_o,
   output logic irq_o
);

   // Elaboration check: the request bundle carries a fixed 12-bit address
   if (ADDR_W != 12) begin
      $error("ADDR_W must equal the 12-bit request address width");
   end

   logic [7:0] osc_trim_q, temp_trim_q, test_q;
   logic [15:0] rate_q;
   logic clksel_q, fe_q, ie_q, flag_q, loaded_q;
   logic [1:0] sync_q;
   logic [17:0] cnt_q;
   pwt_state_t state_q;
   logic [7:0] rdata;
   logic hit, unit, wr, setup, mapped;
   logic [11:0] idx;

   // Word index of an APB address
   function automatic logic [11:0] addr_idx(input logic [11:0] a);
      return {2'h0, a[11:2]};
   endfunction

   // Terminal count for the chosen clock source
   function automatic logic [17:0] last_cnt(input logic [15:0] r,
                                            input logic bus);
      if (bus) begin
         return {1'b0, r, 1'b1};
      end
      return {r, 2'h3};
   endfunction

   assign idx = addr_idx(apb_req_i.paddr);
   assign setup = apb_req_i.psel && !apb_req_i.penable;
   assign wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite
      && apb_rsp_o.pready;

   // Read mux and address decode
   always_comb begin
      rdata = 8'h00;
      mapped = 1'b1;
      case (idx)
         `PWT_IDX_STATUS: rdata = {7'h00, flag_q};
         `PWT_IDX_MASK: rdata = {7'h00, ie_q};
         `PWT_IDX_CTRL: rdata = {clksel_q, 4'h0, fe_q, ie_q, flag_q};
         `PWT_IDX_OSC_TRIM: rdata = osc_trim_q;
         `PWT_IDX_RATE_HI: rdata = rate_q[15:8];
         `PWT_IDX_RATE_LO: rdata = rate_q[7:0];
         `PWT_IDX_TEST: rdata = test_q;
         `PWT_IDX_TEMP_TRIM: rdata = temp_trim_q;
         default: mapped = 1'b0;
      endcase
   end

   // APB answer: no wait states, data latched in setup
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         apb_rsp_o <= '0;
      end else begin
         apb_rsp_o.pready <= setup;
         if (setup) begin
            apb_rsp_o.prdata <= {24'h000000, rdata};
            apb_rsp_o.pslverr <= !mapped;
         end
      end
   end

   // Trim registers, loaded once after reset release
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         loaded_q <= 1'b0;
         osc_trim_q <= 8'h00;
         temp_trim_q <= 8'h00;
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         // Unused bits stay zero so they read back as zero
         osc_trim_q <= {flash_osc_trim_i[7:2], 2'h0};
         temp_trim_q <= {flash_temp_trim_i[7], 3'h0,
            flash_temp_trim_i[3:0]};
      end else if (wr && idx == `PWT_IDX_OSC_TRIM) begin
         osc_trim_q <= {apb_req_i.pwdata[7:2], 2'h0};
      end else if (wr && idx == `PWT_IDX_TEMP_TRIM) begin
         temp_trim_q <= {apb_req_i.pwdata[7], 3'h0, apb_req_i.pwdata[3:0]};
      end
   end

   // Trim outputs to the analog side
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         slow_osc_trim_o <= '0;
         temp_offset_en_o <= 1'b0;
         temp_offset_o <= 4'h0;
      end else begin
         // Signed, MSB lengthens, lower bits shorten
         slow_osc_trim_o <= signed'(osc_trim_q[`PWT_OSC_TRIM_MSB:
            `PWT_OSC_TRIM_LSB]);
         temp_offset_en_o <= temp_trim_q[`PWT_TEMP_EN];
         // Binary weighted code, zero while disabled
         temp_offset_o <= temp_trim_q[`PWT_TEMP_EN] ?
            temp_trim_q[`PWT_TEMP_TRIM_MSB:0] : 4'h0;
      end
   end

   // Factory test register
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         test_q <= `PWT_TEST_RST;
      end else if (wr && idx == `PWT_IDX_TEST && special_mode_i) begin
         test_q <= apb_req_i.pwdata[7:0];
      end
   end
   assign factory_test_o = test_q;

   // Rate bytes, frozen while enabled
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rate_q <= `PWT_RATE_RST;
      end else if (wr && !fe_q) begin
         if (idx == `PWT_IDX_RATE_HI) begin
            rate_q[15:8] <= apb_req_i.pwdata[7:0];
         end
         if (idx == `PWT_IDX_RATE_LO) begin
            rate_q[7:0] <= apb_req_i.pwdata[7:0];
         end
      end
   end

   // Control bits: enable, clock select, irq enable
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fe_q <= 1'b0;
         ie_q <= 1'b0;
         clksel_q <= 1'b0;
      end else if (wr && idx == `PWT_IDX_CTRL) begin
         fe_q <= apb_req_i.pwdata[`PWT_CTRL_FE];
         ie_q <= apb_req_i.pwdata[`PWT_CTRL_IE];
         if (!fe_q && !apb_req_i.pwdata[`PWT_CTRL_FE]) begin
            clksel_q <= apb_req_i.pwdata[`PWT_CTRL_CLKSEL];
         end
      end else if (wr && idx == `PWT_IDX_MASK) begin
         ie_q <= apb_req_i.pwdata[0];
      end
   end

   // Timeout flag: set wins over a write-one clear
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flag_q <= 1'b0;
      end else if (hit) begin
         flag_q <= 1'b1;
      end else if (wr && (idx == `PWT_IDX_CTRL || idx == `PWT_IDX_STATUS)
                   && apb_req_i.pwdata[`PWT_CTRL_FLAG]) begin
         flag_q <= 1'b0;
      end
   end

   // Counting unit: bus cycle or slow oscillator tick
   assign unit = clksel_q || slow_osc_tick_i;
   assign hit = state_q == PWT_RUN && unit
      && cnt_q == last_cnt(rate_q, clksel_q);

   // Timer sequencing with gate release on the slow clock
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= PWT_IDLE;
         sync_q <= 2'h0;
         cnt_q <= '0;
      end else begin
         case (state_q)
            PWT_IDLE: begin
               cnt_q <= '0;
               sync_q <= 2'h0;
               if (fe_q) begin
                  state_q <= clksel_q ? PWT_RUN : PWT_SYNC;
               end
            end
            PWT_SYNC: begin
               // Gate opens after two ticks
               if (!fe_q) begin
                  state_q <= PWT_IDLE;
               end else if (slow_osc_tick_i) begin
                  sync_q <= sync_q + 2'h1;
                  if (sync_q + 2'h1 == `PWT_SYNC_TICKS) begin
                     state_q <= PWT_RUN;
                  end
               end
            end
            PWT_RUN: begin
               if (!fe_q) begin
                  state_q <= PWT_IDLE;
               end else if (hit) begin
                  cnt_q <= '0;
               end else if (unit) begin
                  cnt_q <= cnt_q + 18'h00001;
               end
            end
            default: state_q <= PWT_IDLE;
         endcase
      end
   end

   // Interrupt level from next-state flag and enable
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= (hit || (flag_q && !(wr && apb_req_i.pwdata[0]
            && (idx == `PWT_IDX_CTRL || idx == `PWT_IDX_STATUS))))
            && ((wr && idx == `PWT_IDX_CTRL) ?
            apb_req_i.pwdata[`PWT_CTRL_IE] : (wr && idx == `PWT_IDX_MASK) ?
            apb_req_i.pwdata[0] : ie_q);
      end
   end

   // Helper: cycles since last timeout in bus mode
   logic [17:0] gap_q;
   logic seen_q;
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gap_q <= '0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= hit ? 18'h00001 : gap_q + 18'h00001;
         seen_q <= (state_q == PWT_RUN && clksel_q) && (seen_q || hit);
      end
   end

   sequence rate_wr_s;
      wr && (idx == `PWT_IDX_RATE_HI || idx == `PWT_IDX_RATE_LO);
   endsequence
   sequence enable_slow_s;
      $rose(fe_q) && !clksel_q;
   endsequence

   rate_lock_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      rate_wr_s and fe_q |=> $stable(rate_q))
      else $error("rate changed while enabled");
   flag_set_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      hit |=> flag_q)
      else $error("timeout did not set flag");
   irq_level_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      irq_o == (flag_q && ie_q))
      else $error("irq level wrong");
   bus_period_a: assert property (@(posedge clock_i)
      disable iff (!resetn_i)
      hit && seen_q && clksel_q |-> gap_q == {1'b0, rate_q, 1'b0}
         + 18'h00002)
      else $error("bus clock period wrong");
   trim_load_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      $rose(loaded_q) |-> osc_trim_q == ($past(flash_osc_trim_i) & 8'hfc)
         && temp_trim_q == ($past(flash_temp_trim_i) & 8'h8f))
      else $error("trim not loaded from flash");
   test_lock_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      wr && idx == `PWT_IDX_TEST && !special_mode_i |=> $stable(test_q))
      else $error("test register written in normal mode");
   clksel_lock_a: assert property (@(posedge clock_i)
      disable iff (!resetn_i)
      fe_q || $rose(fe_q) |-> $stable(clksel_q))
      else $error("clock select changed while enabling");
   offset_gate_a: assert property (@(posedge clock_i)
      disable iff (!resetn_i)
      !temp_offset_en_o |-> temp_offset_o == 4'h0)
      else $error("offset applied while disabled");
   slow_sync_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
      enable_slow_s ##1 fe_q |-> state_q == PWT_SYNC)
      else $error("slow clock gate not synchronised");

endmodule
`default_nettype wire

/* File: rtl/pwt_defs.svh */
`ifndef PWT_DEFS_SVH
`define PWT_DEFS_SVH
// Register indices; byte address is four times the index
`define PWT_IDX_STATUS 12'h2f0
`define PWT_IDX_MASK 12'h2f1
`define PWT_IDX_CTRL 12'h2f2
`define PWT_IDX_OSC_TRIM 12'h2f3
`define PWT_IDX_RATE_HI 12'h2f4
`define PWT_IDX_RATE_LO 12'h2f5
`define PWT_IDX_TEST 12'h2f6
`define PWT_IDX_TEMP_TRIM 12'h2f7
// Control register fields
`define PWT_CTRL_CLKSEL 7
`define PWT_CTRL_FE 2
`define PWT_CTRL_IE 1
`define PWT_CTRL_FLAG 0
// Trim register fields
`define PWT_OSC_TRIM_MSB 7
`define PWT_OSC_TRIM_LSB 2
`define PWT_TEMP_EN 7
`define PWT_TEMP_TRIM_MSB 3
// Reset values
`define PWT_RATE_RST 16'h0000
`define PWT_TEST_RST 8'h00
// Slow clock gate release needs this many oscillator ticks
`define PWT_SYNC_TICKS 2'h2
`endif

/* File: rtl/pwt_pkg.sv */
`default_nettype none
package pwt_pkg;
   // APB request bundle from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pwt_apb_req_t;
   // APB answer bundle to the master
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pwt_apb_rsp_t;
   // Periodic timer state
   typedef enum logic [1:0] {PWT_IDLE, PWT_SYNC, PWT_RUN} pwt_state_t;
endpackage
`default_nettype wire

/* File: tb/test_periodic_wakeup_timer_trim.sv */
`include "pwt_defs.svh"
`default_nettype none
// Compare helper: counts every check and reports a mismatch at once
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_periodic_wakeup_timer_trim import pwt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   pwt_apb_req_t req = '0;
   pwt_apb_rsp_t rsp;
   logic tick = 1'b0;
   logic special = 1'b0;
   logic [7:0] fo = 8'h00;
   logic [7:0] ft = 8'h00;
   logic signed [5:0] trim_o;
   logic ten_o;
   logic [3:0] toff_o;
   logic [7:0] test_o;
   logic irq;
   logic [1:0] tk = 2'h0;
   logic [31:0] rd;
   logic err;
   logic [15:0] r;
   logic [7:0] v;
   logic [7:0] w;
   int miscompares = 0;
   int compares = 0;
   int seed = 11646;
   int cyc = 0;
   time t0;

   pwt_top dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .apb_req_i(req),
      .apb_rsp_o(rsp), .slow_osc_tick_i(tick), .special_mode_i(special),
      .flash_osc_trim_i(fo), .flash_temp_trim_i(ft), .slow_osc_trim_o(trim_o),
      .temp_offset_en_o(ten_o), .temp_offset_o(toff_o),
      .factory_test_o(test_o), .irq_o(irq));

   // Clock and slow oscillator stand-in: one tick every four cycles
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      tk <= tk + 2'h1;
      tick <= (tk == 2'h0);
   end

   // Closing report
   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] idx,
                      input logic [7:0] d);
      @(posedge clock_i);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {idx[9:0], 2'b00};
      req.pwdata <= {24'h0, d};
      @(posedge clock_i);
      req.penable <= 1'b1;
      do @(posedge clock_i); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   // Trim registers and the outputs they drive
   task automatic trims(input logic [7:0] o, input logic [7:0] t);
      apb(1'b0, `PWT_IDX_OSC_TRIM, 8'h00);
      `CHK(rd, {24'h0, o & 8'hfc})
      apb(1'b0, `PWT_IDX_TEMP_TRIM, 8'h00);
      `CHK(rd, {24'h0, t & 8'h8f})
      `CHK(trim_o, o[7:2])
      `CHK(ten_o, t[7])
      `CHK(toff_o, t[7] ? t[3:0] : 4'h0)
   endtask

   // Expected timeout period in bus cycles; a slow tick is four cycles
   function automatic int exp_period(input logic [15:0] rt,
                                     input logic bus);
      if (bus) begin
         return 2 * (int'(rt) + 1);
      end
      return 2 * (int'(rt) + 1) * 2 * 4;
   endfunction

   // Wait for the interrupt level; running out of time is a mismatch
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 3000) begin
         @(posedge clock_i);
         n++;
      end
      `CHK(irq, lvl)
   endtask

   // Rise-to-rise interrupt spacing, flag cleared in between
   task automatic period(input int exp_cyc);
      for (int i = 0; i < 2; i++) begin
         t0 = $time;
         apb(1'b1, `PWT_IDX_STATUS, 8'h01);
         wait_irq(1'b0);
         wait_irq(1'b1);
      end
      `CHK(($time - t0) / 10, exp_cyc)
   endtask

   initial begin
      fo <= 8'($random(seed));
      ft <= 8'($random(seed));
      repeat (20) @(posedge clock_i);
      resetn_i <= 1'b1;
      trims(fo, ft);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         w = (i == 0) ? 8'h0f : 8'($random(seed));
         apb(1'b1, `PWT_IDX_OSC_TRIM, v);
         apb(1'b1, `PWT_IDX_TEMP_TRIM, w);
         trims(v, w);
      end
      $display("test trims done");
      // Factory test register: locked outside special mode
      apb(1'b0, `PWT_IDX_TEST, 8'h00);
      `CHK(rd[7:0], `PWT_TEST_RST)
      `CHK(err, 1'b0)
      v = 8'($random(seed)) | 8'h01;
      apb(1'b1, `PWT_IDX_TEST, v);
      apb(1'b0, `PWT_IDX_TEST, 8'h00);
      `CHK(rd[7:0], 8'h00)
      special <= 1'b1;
      apb(1'b1, `PWT_IDX_TEST, v);
      apb(1'b0, `PWT_IDX_TEST, 8'h00);
      `CHK(rd[7:0], v)
      `CHK(test_o, v)
      special <= 1'b0;
      apb(1'b0, 12'h2f8, 8'h00);
      `CHK({err, rd}, 33'h100000000)
      $display("test factory done");
      // Bus clock mode
      apb(1'b0, `PWT_IDX_RATE_LO, 8'h00);
      `CHK(rd[7:0], `PWT_RATE_RST)
      r = 16'd4 + (16'($random(seed)) & 16'h000f);
      apb(1'b1, `PWT_IDX_RATE_HI, r[15:8]);
      apb(1'b1, `PWT_IDX_RATE_LO, r[7:0]);
      apb(1'b1, `PWT_IDX_CTRL, 8'h80);
      apb(1'b1, `PWT_IDX_CTRL, 8'h86);
      apb(1'b1, `PWT_IDX_RATE_LO, 8'hff);
      apb(1'b0, `PWT_IDX_RATE_LO, 8'h00);
      `CHK(rd[7:0], r[7:0])
      period(exp_period(r, 1'b1));
      apb(1'b1, `PWT_IDX_CTRL, 8'h86);
      apb(1'b0, `PWT_IDX_CTRL, 8'h00);
      `CHK(rd[7:0], 8'h87)
      apb(1'b1, `PWT_IDX_MASK, 8'h00);
      repeat (3) @(posedge clock_i);
      `CHK(irq, 1'b0)
      apb(1'b1, `PWT_IDX_MASK, 8'h01);
      repeat (3) @(posedge clock_i);
      `CHK(irq, 1'b1)
      apb(1'b1, `PWT_IDX_CTRL, 8'h80);
      apb(1'b1, `PWT_IDX_STATUS, 8'h01);
      repeat (60) @(posedge clock_i);
      apb(1'b0, `PWT_IDX_STATUS, 8'h00);
      `CHK({irq, rd[0]}, 2'b00)
      $display("test bus mode done");
      // Slow oscillator mode; enabling write cannot move the clock select
      r = 16'($random(seed)) & 16'h0003;
      apb(1'b1, `PWT_IDX_RATE_LO, r[7:0]);
      apb(1'b1, `PWT_IDX_RATE_HI, 8'h00);
      apb(1'b1, `PWT_IDX_CTRL, 8'h00);
      apb(1'b1, `PWT_IDX_CTRL, 8'h86);
      apb(1'b0, `PWT_IDX_CTRL, 8'h00);
      `CHK(rd[7], 1'b0)
      period(exp_period(r, 1'b0));
      apb(1'b1, `PWT_IDX_CTRL, 8'h00);
      $display("test slow mode done");
      test_done();
   end
endmodule
`default_nettype wire
